// ---- rtl/cfg_flash_pkg.sv ----
// Package for the serial configuration flash port
// Assumes a single clk domain at 125 MHz sampling the link pins
package cfg_flash_pkg;
    // ----------------------------------------
    // Array sizing
    // ----------------------------------------
    localparam int ADDR_BITS = 24;
    localparam int MEM_ADDR_BITS = 12;
    localparam int MEM_WORDS = 4096;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // ----------------------------------------
    // Instructions
    // ----------------------------------------
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam int OP_BITS = 8;
    localparam int ADDR_END_BIT = 32;
    localparam logic [5:0] ADDR_END_COUNT = 6'h20;
    // ----------------------------------------
    // Synchroniser and timing
    // ----------------------------------------
    localparam int SYNC_STAGES = 3;
    localparam int CLK_PERIOD_NS = 8;
    localparam int LINK_PERIOD_NS = 125;
    localparam int LINK_CYCLES = (LINK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_READ,
        ST_PROG
    } phase_type;
endpackage : cfg_flash_pkg

// ---- rtl/cfg_flash_mem.sv ----
// Byte array of the flash, read data registered
// Assumes one write or read per clk, erased contents at power up
`timescale 1ns/1ps
module cfg_flash_mem import cfg_flash_pkg::*; #(
    parameter int WORDS = 4096,
    parameter int AW = 12
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:WORDS-1];
    // ----------------------------------------
    // Erased array at delivery
    // ----------------------------------------
    initial begin
        for (int i = 0; i < WORDS; i++) begin
            mem[i] = ERASED_BYTE;
        end
    end
    // ----------------------------------------
    // Program clears bits only
    // ----------------------------------------
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= mem[wr_addr] & wr_data;
        end
    end
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : cfg_flash_mem

// ---- rtl/cfg_flash_port.sv ----
// Serial configuration flash, four-wire slave end
// Assumes master drives serial_shift_clock slower than clk / 6
`timescale 1ns/1ps
// What this block does
// - Four wires: data, clock, command, select
// - Read data changes on falling clock edges
// - One flash feeds the master only
// - Single device, no cascade output
// - Array delivered erased, reads ones
module cfg_flash_port import cfg_flash_pkg::*; #(
    parameter int WORDS = MEM_WORDS,
    parameter int AW = MEM_ADDR_BITS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic serial_shift_clock,
    input wire logic flash_cmd_in,
    input wire logic flash_select_n,
    output logic master_bit_in_out,
    output logic master_bit_in_oe,
    output logic busy
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [SYNC_STAGES-1:0] clk_sync_reg, cmd_sync_reg, sel_sync_reg;
    logic clk_state_reg, sel_state_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clk_sync_reg <= '0;
            cmd_sync_reg <= '0;
            sel_sync_reg <= '1;
        end else begin
            clk_sync_reg <= {clk_sync_reg[1:0], serial_shift_clock};
            cmd_sync_reg <= {cmd_sync_reg[1:0], flash_cmd_in};
            sel_sync_reg <= {sel_sync_reg[1:0], flash_select_n};
        end
    end
    wire clk_agree = clk_sync_reg[2] == clk_sync_reg[1];
    wire sel_agree = sel_sync_reg[2] == sel_sync_reg[1];
    wire clk_next = clk_agree ? clk_sync_reg[1] : clk_state_reg;
    wire sel_next = sel_agree ? sel_sync_reg[1] : sel_state_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clk_state_reg <= 1'b0;
            sel_state_reg <= 1'b1;
        end else begin
            clk_state_reg <= clk_next;
            sel_state_reg <= sel_next;
        end
    end
    wire rise = clk_next & ~clk_state_reg;
    wire fall = ~clk_next & clk_state_reg;
    wire selected = ~sel_next;
    wire cmd_bit = cmd_sync_reg[2];
    // ----------------------------------------
    // Opcode decode
    // ----------------------------------------
    function automatic logic op_matches(input logic [31:0] word, input logic [7:0] op);
        return word[31:24] == op;
    endfunction : op_matches
    // ----------------------------------------
    // Command shifter
    // ----------------------------------------
    phase_type phase_reg, phase_next;
    logic [5:0] count_reg;
    logic [31:0] shift_reg;
    logic [ADDR_BITS-1:0] addr_reg;
    logic [2:0] bit_reg;
    logic [7:0] rd_data;
    logic [7:0] byte_reg;
    wire [31:0] shift_next = {shift_reg[30:0], cmd_bit};
    wire last_addr_bit = count_reg == ADDR_END_COUNT - 6'h01;
    wire [ADDR_BITS-1:0] addr_from_shift = shift_next[ADDR_BITS-1:0];
    wire prog_byte_done = phase_reg == ST_PROG && rise && bit_reg == 3'h7;
    wire [ADDR_BITS-1:0] addr_inc = addr_reg + 24'h000001;
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            ST_IDLE: begin
                if (rise && selected) begin
                    phase_next = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (rise && last_addr_bit) begin
                    if (op_matches(shift_next, OP_READ)) begin
                        phase_next = ST_READ;
                    end else if (op_matches(shift_next, OP_PROGRAM)) begin
                        phase_next = ST_PROG;
                    end else begin
                        phase_next = ST_IDLE;
                    end
                end
            end
            ST_READ: phase_next = ST_READ;
            ST_PROG: phase_next = ST_PROG;
            default: phase_next = ST_IDLE;
        endcase
        if (!selected) begin
            phase_next = ST_IDLE;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_reg <= ST_IDLE;
            count_reg <= '0;
            shift_reg <= '0;
        end else begin
            phase_reg <= phase_next;
            if (!selected) begin
                count_reg <= '0;
            end else if (rise && (phase_reg == ST_IDLE || phase_reg == ST_ADDR)) begin
                count_reg <= count_reg + 6'h01;
                shift_reg <= shift_next;
            end
        end
    end
    // ----------------------------------------
    // Address, bit pointer and program byte
    // ----------------------------------------
    wire to_stream = phase_reg == ST_ADDR && phase_next != ST_ADDR && phase_next != ST_IDLE;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr_reg <= '0;
            bit_reg <= '0;
            byte_reg <= '0;
        end else if (to_stream) begin
            addr_reg <= addr_from_shift;
            bit_reg <= '0;
        end else if (phase_reg == ST_READ && fall && selected) begin
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
                addr_reg <= addr_inc;
            end
        end else if (phase_reg == ST_PROG && rise && selected) begin
            byte_reg <= {byte_reg[6:0], cmd_bit};
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
                addr_reg <= addr_inc;
            end
        end
    end
    // ----------------------------------------
    // Memory
    // ----------------------------------------
    wire [AW-1:0] mem_addr = addr_reg[AW-1:0];
    wire mem_wr_en = prog_byte_done && selected;
    cfg_flash_mem #(.WORDS(WORDS), .AW(AW)) u_mem (
        .clk(clk),
        .wr_en(mem_wr_en),
        .wr_addr(mem_addr),
        .wr_data({byte_reg[6:0], cmd_bit}),
        .rd_addr(mem_addr),
        .rd_data(rd_data)
    );
    // ----------------------------------------
    // Data pin drive
    // ----------------------------------------
    wire [2:0] sel_bit = 3'h7 - bit_reg;
    wire drive_bit = rd_data[sel_bit];
    wire in_read = phase_reg == ST_READ;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            master_bit_in_out <= 1'b0;
            master_bit_in_oe <= 1'b0;
            busy <= 1'b0;
        end else begin
            busy <= selected && phase_reg != ST_IDLE;
            master_bit_in_oe <= selected && phase_reg == ST_READ;
            if (phase_reg == ST_READ && fall) begin
                master_bit_in_out <= rd_data[sel_bit];
            end
        end
    end
    // ----------------------------------------
    // Check sequences
    // ----------------------------------------
    sequence s_deselected;
        !selected;
    endsequence
    sequence s_read_fall;
        phase_reg == ST_READ && fall;
    endsequence
    sequence s_byte_end;
        phase_reg == ST_READ && fall && selected && bit_reg == 3'h7;
    endsequence
    sequence s_read_decoded;
        phase_reg == ST_ADDR && rise && last_addr_bit && selected
        && op_matches(shift_next, OP_READ);
    endsequence
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_float_deselect: assert property (@(posedge clk) disable iff (reset)
        s_deselected |=> !master_bit_in_oe) else $error("data driven while deselected");
    a_out_on_fall: assert property (@(posedge clk) disable iff (reset)
        $changed(master_bit_in_out) |-> $past(fall)) else $error("data moved off falling edge");
    a_idle_drops: assert property (@(posedge clk) disable iff (reset)
        s_deselected |=> phase_reg == ST_IDLE) else $error("instruction survived deselect");
    a_read_enter: assert property (@(posedge clk) disable iff (reset)
        s_read_decoded |=> phase_reg == ST_READ) else $error("read missed");
    a_oe_read: assert property (@(posedge clk) disable iff (reset)
        master_bit_in_oe |-> $past(in_read)) else $error("drive outside read");
    a_bit_from_array: assert property (@(posedge clk) disable iff (reset)
        s_read_fall |=> master_bit_in_out == $past(drive_bit)) else $error("wrong array bit");
    a_oe_in_read: assert property (@(posedge clk) disable iff (reset)
        s_read_fall ##0 selected |=> master_bit_in_oe) else $error("read data not driven");
    a_byte_advance: assert property (@(posedge clk) disable iff (reset)
        s_byte_end |=> addr_reg == $past(addr_inc)) else $error("stream did not advance");
    a_busy_deselect: assert property (@(posedge clk) disable iff (reset)
        s_deselected |=> !busy) else $error("busy while deselected");
    a_write_in_prog: assert property (@(posedge clk) disable iff (reset)
        mem_wr_en |-> phase_reg == ST_PROG && rise) else $error("write outside program");
endmodule : cfg_flash_port

// ---- verif/cfg_master_model.sv ----
// Behavioural configuration master driving the flash port
// Assumes clk at 125 MHz; link clock period 125 ns, free running against clk
`timescale 1ns/1ps
module cfg_master_model import cfg_flash_pkg::*; (
    input wire logic clk,
    input wire logic data_in,
    input wire logic data_oe,
    output logic shift_clk,
    output logic cmd,
    output logic sel_n
);
    localparam realtime HALF_LINK = LINK_PERIOD_NS / 2.0;
    logic config_complete;
    logic config_fault_n;
    logic user_mode;
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial begin
        shift_clk = 1'b0;
        cmd = 1'b0;
        sel_n = 1'b1;
        config_complete = 1'b0;
        config_fault_n = 1'b1;
        user_mode = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // ----------------------------------------
    // Link transfers
    // ----------------------------------------
    task automatic send(input logic [31:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            cmd <= w[i];
            #HALF_LINK;
            shift_clk <= 1'b1;
            #HALF_LINK;
            shift_clk <= 1'b0;
        end
    endtask : send
    task automatic start(input logic [7:0] op, input logic [23:0] a);
        sel_n <= 1'b0;
        tick(8);
        send({op, a}, 32);
    endtask : start
    task automatic get(input int n, output logic [31:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin
            #HALF_LINK;
            shift_clk <= 1'b1;
            #HALF_LINK;
            v = {v[30:0], data_oe === 1'b1 ? data_in : 1'bx};
            shift_clk <= 1'b0;
        end
    endtask : get
    task automatic stop;
        tick(8);
        sel_n <= 1'b1;
        cmd <= ~cmd;
        tick(16);
    endtask : stop
    // ----------------------------------------
    // Completion handshake and retry
    // ----------------------------------------
    task automatic configure(input int n, input logic [31:0] image, input logic early_done,
        output int tries);
        logic [31:0] r;
        tries = 0;
        for (int k = 0; k < 2; k++) begin
            start(OP_READ, 24'h000000);
            get(n, r);
            stop();
            tries++;
            if (r === image && !(early_done && k == 0)) begin
                config_complete <= 1'b1;
                tick(8);
                user_mode <= config_complete;
                tick(1);
                return;
            end
            config_fault_n <= 1'b0;
            tick(8);
            config_fault_n <= 1'b1;
        end
    endtask : configure
endmodule : cfg_master_model

// ---- verif/active_serial_config_flash_port_bench.sv ----
// Testbench for the serial configuration flash port
// Assumes cfg_master_model as the master on the link
`timescale 1ns/1ps
module active_serial_config_flash_port_bench import cfg_flash_pkg::*;;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sck, cmd, sel_n, bit_out, bit_oe, busy;
    logic [31:0] v;
    int failures = 0;
    int n_tests = 0;
    always #4 clk = ~clk;
    cfg_flash_port dut (.clk(clk), .reset(reset), .serial_shift_clock(sck),
        .flash_cmd_in(cmd), .flash_select_n(sel_n), .master_bit_in_out(bit_out),
        .master_bit_in_oe(bit_oe), .busy(busy));
    cfg_master_model m (.clk(clk), .data_in(bit_out), .data_oe(bit_oe),
        .shift_clk(sck), .cmd(cmd), .sel_n(sel_n));
    // ----------------------------------------
    // Checking and verdict
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic idle_check;
        check({30'h0, bit_oe, busy}, 32'h0);
    endtask : idle_check
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_erased;
        m.start(OP_READ, 24'h000000);
        m.get(16, v);
        check(v, 32'h0000FFFF);
        check({31'h0, busy}, 32'h1);
        m.stop();
        idle_check();
    endtask : t_erased
    task automatic t_prog;
        m.start(OP_PROGRAM, 24'h000010);
        m.send(32'hA5, 8);
        m.stop();
        m.start(OP_READ, 24'h00000F);
        m.get(24, v);
        check(v, 32'h00FFA5FF);
        m.stop();
    endtask : t_prog
    task automatic t_abort;
        m.start(OP_READ, 24'h000010);
        m.get(4, v);
        check(v, 32'hA);
        m.stop();
        idle_check();
        m.send(32'h0200FFFF, 32);
        idle_check();
        m.start(OP_READ, 24'h000010);
        m.get(8, v);
        check(v, 32'hA5);
        m.stop();
    endtask : t_abort
    task automatic t_wrap;
        m.start(OP_PROGRAM, 24'h000000);
        m.send(32'h3C, 8);
        m.stop();
        m.start(OP_READ, 24'h000FFF);
        m.get(16, v);
        check(v, 32'h0000FF3C);
        m.stop();
    endtask : t_wrap
    task automatic t_config;
        int tries;
        m.configure(16, 32'h00003CFF, 1'b1, tries);
        check(tries, 32'h2);
        check({30'h0, m.config_complete, m.user_mode}, 32'h3);
        check({31'h0, m.config_fault_n}, 32'h1);
    endtask : t_config
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        idle_check();
        t_erased();
        t_prog();
        t_abort();
        t_wrap();
        t_config();
        finish_test();
    end
    initial begin
        #200000;
        failures++;
        finish_test();
    end
endmodule : active_serial_config_flash_port_bench
